// ---- fifo_status_pkg.sv ----
package fifo_status_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] STATUS_FLUSH_ADDR = 12'h84C;
    localparam logic [11:0] CONTROL_ADDR = 12'h900;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLUSH_ALL_BIT = 10;
    localparam int MASTER_FLUSH_BIT = 9;
    localparam int SLAVE_FLUSH_BIT = 8;
    localparam int MRX_LSB = 6;
    localparam int MTX_LSB = 4;
    localparam int SRX_LSB = 2;
    localparam int STX_LSB = 0;
    localparam int SEL_LSB = 0;

    // ------------------------------------------------------------
    // FIFO shape and occupancy codes
    // ------------------------------------------------------------
    localparam int DEPTH = 2;
    localparam int NUM_IDS = 4;
    localparam int NUM_FIFOS = 8;
    localparam logic [1:0] COUNT_EMPTY = 2'h0;
    localparam logic [1:0] COUNT_ONE = 2'h1;
    localparam logic [1:0] COUNT_TWO = 2'h2;

    // FIFO index map: 0 master rx, 1 master tx, 2 slave rx, 3 slave tx, 4..7 id fifos
    localparam int IDX_MRX = 0;
    localparam int IDX_MTX = 1;
    localparam int IDX_SRX = 2;
    localparam int IDX_STX = 3;
    localparam int IDX_ID0 = 4;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

endpackage

// ---- i2c_fifo_status_flush.sv ----
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module i2c_fifo_status_flush (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic per_address_fifo_enable_i,
    input wire logic arb_lost_i,
    input wire logic nack_i,
    input wire fifo_status_pkg::byte_beat_t push_i [8],
    output logic push_ready_o [8],
    output fifo_status_pkg::byte_beat_t pop_o [8],
    input wire logic pop_ready_i [8],
    output logic master_flush_needed_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic flush_all_q;
    logic master_flush_q;
    logic slave_flush_q;
    logic [1:0] sel_q;
    logic flush_needed_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [1:0] count_q [8];
    logic [7:0] mem_q [8][2];
    logic flush_w [8];
    logic access_w;
    logic commit_w;

    // Decode: true for a completed write to the given word
    function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] target,
                                    input logic s, input logic e, input logic w);
        return s && e && w && (a == target);
    endfunction

    assign access_w = psel && penable && !pready_q;
    // Writes land only on the edge where the master sees pready high
    assign commit_w = psel && penable && pready_q;

    // Control bits; flush bits sit in the status word, the selector alone in the control word
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flush_all_q <= 1'b0;
            master_flush_q <= 1'b0;
            slave_flush_q <= 1'b0;
            sel_q <= 2'h0;
        end else if (wr_hit(paddr, fifo_status_pkg::STATUS_FLUSH_ADDR, commit_w, 1'b1, pwrite)) begin
            flush_all_q <= pwdata[fifo_status_pkg::FLUSH_ALL_BIT];
            master_flush_q <= pwdata[fifo_status_pkg::MASTER_FLUSH_BIT];
            slave_flush_q <= pwdata[fifo_status_pkg::SLAVE_FLUSH_BIT];
        end else if (wr_hit(paddr, fifo_status_pkg::CONTROL_ADDR, commit_w, 1'b1, pwrite)) begin
            sel_q <= pwdata[fifo_status_pkg::SEL_LSB +: 2];
        end
    end

    // Sticky hint that the master FIFO needs flushing; set wins over clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flush_needed_q <= 1'b0;
        end else if (arb_lost_i || nack_i) begin
            flush_needed_q <= 1'b1;
        end else if (master_flush_q) begin
            flush_needed_q <= 1'b0;
        end
    end

    // Flush steering per FIFO; held while the flush bit stays set
    always_comb begin
        for (int k = 0; k < fifo_status_pkg::NUM_FIFOS; k++) begin
            flush_w[k] = 1'b0;
        end
        flush_w[fifo_status_pkg::IDX_MTX] = master_flush_q;
        // Only meaningful without ID mode; gated so it cannot hit ID FIFOs
        flush_w[fifo_status_pkg::IDX_STX] = slave_flush_q && !per_address_fifo_enable_i;
        for (int k = 0; k < fifo_status_pkg::NUM_IDS; k++) begin
            flush_w[fifo_status_pkg::IDX_ID0 + k] = flush_all_q && per_address_fifo_enable_i;
        end
    end

    // ------------------------------------------------------------
    // Two-entry FIFOs
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < fifo_status_pkg::NUM_FIFOS; g++) begin : g_fifo
            logic push_en;
            logic do_push;
            logic do_pop;
            if (g >= fifo_status_pkg::IDX_ID0) begin : g_id
                // ID FIFOs load only from the selected identity
                assign push_en = per_address_fifo_enable_i
                    && (sel_q == 2'(g - fifo_status_pkg::IDX_ID0));
            end else begin : g_plain
                assign push_en = 1'b1;
            end
            assign do_push = push_i[g].valid && push_ready_o[g];
            assign do_pop = pop_o[g].valid && pop_ready_i[g];

            // Occupancy stays 0..2; the reserved code is unreachable
            always_ff @(posedge ref_clk_i) begin
                if (rst_i || flush_w[g]) begin
                    count_q[g] <= fifo_status_pkg::COUNT_EMPTY;
                end else if (do_push && !do_pop) begin
                    count_q[g] <= count_q[g] + 2'h1;
                end else if (do_pop && !do_push) begin
                    count_q[g] <= count_q[g] - 2'h1;
                end
            end

            // Data shifts down on pop; push lands at next free slot
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    mem_q[g][0] <= 8'h00;
                    mem_q[g][1] <= 8'h00;
                end else begin
                    if (do_pop) begin
                        mem_q[g][0] <= mem_q[g][1];
                    end
                    if (do_push) begin
                        if (do_pop) begin
                            mem_q[g][count_q[g] == fifo_status_pkg::COUNT_TWO ? 1 : 0]
                                <= push_i[g].data;
                        end else begin
                            mem_q[g][count_q[g][0]] <= push_i[g].data;
                        end
                    end
                end
            end

            // Registered handshakes; ready only follows a cycle in which the FIFO was empty
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    push_ready_o[g] <= 1'b0;
                    pop_o[g] <= '0;
                end else begin
                    push_ready_o[g] <= push_en && !flush_w[g]
                        && (count_q[g] == fifo_status_pkg::COUNT_EMPTY);
                    pop_o[g].valid <= !flush_w[g] && !do_pop
                        && (count_q[g] != fifo_status_pkg::COUNT_EMPTY);
                    pop_o[g].data <= mem_q[g][0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access_w;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (access_w) begin
                if (paddr == fifo_status_pkg::STATUS_FLUSH_ADDR) begin
                    if (!pwrite) begin
                        prdata_q[fifo_status_pkg::FLUSH_ALL_BIT] <= flush_all_q;
                        prdata_q[fifo_status_pkg::MRX_LSB +: 2] <=
                            count_q[fifo_status_pkg::IDX_MRX];
                        prdata_q[fifo_status_pkg::MTX_LSB +: 2] <=
                            count_q[fifo_status_pkg::IDX_MTX];
                        prdata_q[fifo_status_pkg::SRX_LSB +: 2] <=
                            count_q[fifo_status_pkg::IDX_SRX];
                        prdata_q[fifo_status_pkg::STX_LSB +: 2] <=
                            count_q[fifo_status_pkg::IDX_STX];
                    end
                end else if (paddr == fifo_status_pkg::CONTROL_ADDR) begin
                    if (!pwrite) begin
                        prdata_q[fifo_status_pkg::SEL_LSB +: 2] <= sel_q;
                    end
                end else begin
                    pslverr_q <= 1'b1; // Unmapped word
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign master_flush_needed_o = flush_needed_q;

endmodule

// ---- fifo_status_monitor.sv ----
`timescale 1ns/1ps
module fifo_status_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic arb_lost_i,
    input wire logic nack_i,
    input wire fifo_status_pkg::byte_beat_t push_i [8],
    input wire logic push_ready_o [8],
    input wire fifo_status_pkg::byte_beat_t pop_o [8],
    input wire logic master_flush_needed_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // A status read answer; counts are judged only when software sees them
    wire logic st_rd = pready && !pwrite && paddr == fifo_status_pkg::STATUS_FLUSH_ADDR;
    wire logic mapped = paddr == fifo_status_pkg::STATUS_FLUSH_ADDR
        || paddr == fifo_status_pkg::CONTROL_ADDR;
    sequence s_taken; psel && penable && !pready; endsequence
    sequence s_push(int i); push_i[i].valid && push_ready_o[i]; endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_one_wait_state: assert property (s_taken |=> pready)
        else $error("bus answer not one cycle after access");
    chk_unmapped_err: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    chk_counts_legal: assert property (st_rd |-> prdata[7:6] != 2'h3 && prdata[5:4] != 2'h3
        && prdata[3:2] != 2'h3 && prdata[1:0] != 2'h3) else $error("reserved count code");
    chk_flush_reads_zero: assert property (st_rd |-> prdata[9:8] == 2'h0)
        else $error("flush bits read back as one");
    chk_flag_sets: assert property (arb_lost_i || nack_i |=> master_flush_needed_o)
        else $error("flush flag not raised");
    chk_stx_fill: assert property (s_push(3) |-> ##[1:2] pop_o[3].valid)
        else $error("slave tx byte not presented");
    chk_mrx_fill: assert property (s_push(0) |-> ##[1:2] pop_o[0].valid)
        else $error("master rx byte not presented");
    chk_ready_empty: assert property (push_ready_o[1] |-> !pop_o[1].valid)
        else $error("accepting while holding a byte");
endmodule
bind i2c_fifo_status_flush fifo_status_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arb_lost_i(arb_lost_i), .nack_i(nack_i),
    .push_i(push_i), .push_ready_o(push_ready_o), .pop_o(pop_o),
    .master_flush_needed_o(master_flush_needed_o));

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic en = 1'b0, arb = 1'b0, nack = 1'b0, pready, pslverr, flag, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    fifo_status_pkg::byte_beat_t push_i [8], pop_o [8];
    logic push_ready_o [8], pop_ready_i [8];
    int num_errors = 0, comparisons = 0;
    localparam logic [11:0] SA = fifo_status_pkg::STATUS_FLUSH_ADDR;
    i2c_fifo_status_flush i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .per_address_fifo_enable_i(en), .arb_lost_i(arb),
        .nack_i(nack), .push_i(push_i), .push_ready_o(push_ready_o), .pop_o(pop_o),
        .pop_ready_i(pop_ready_i), .master_flush_needed_o(flag));
    always #5 ref_clk_i = ~ref_clk_i;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic push(input int i, input logic [7:0] d);
        @(posedge ref_clk_i);
        push_i[i] <= '{1'b1, d};
        do @(posedge ref_clk_i); while (push_ready_o[i] !== 1'b1);
        push_i[i] <= '{1'b0, 8'h00};
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_counts;
        for (int i = 0; i < 4; i++) push(i, 8'hA0 + i[7:0]);
        apb(1'b0, SA, 32'h0);
        chk("counts", 32'h0055, {16'h0, rd[15:0]});
        for (int i = 0; i < 4; i++) chk("data", 32'hA0 + i, {24'h0, pop_o[i].data});
        for (int i = 0; i < 4; i++) pop_ready_i[i] <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        for (int i = 0; i < 4; i++) pop_ready_i[i] <= 1'b0;
        apb(1'b0, SA, 32'h0);
        chk("drained", 32'h0, {16'h0, rd[15:0]});
        $display("test counts done");
    endtask
    // Master and slave flush: bit set empties and holds, clearing restores
    task automatic t_flush(input int i, input int b, input int f);
        push(i, 8'h5A);
        if (i == 1) begin
            @(posedge ref_clk_i) arb <= 1'b1;
            @(posedge ref_clk_i) arb <= 1'b0;
            @(posedge ref_clk_i) nack <= 1'b1;
            @(posedge ref_clk_i) nack <= 1'b0;
            chk("flag", 32'h1, {31'h0, flag});
        end
        apb(1'b1, SA, 32'h1 << b);
        apb(1'b0, SA, 32'h0);
        chk("flushed", 32'h0, {30'h0, rd[f +: 2]});
        chk("held", 32'h0, {31'h0, push_ready_o[i]});
        if (i == 1) chk("flag clear", 32'h0, {31'h0, flag});
        apb(1'b1, SA, 32'h0);
        repeat (3) @(posedge ref_clk_i);
        chk("resumed", 32'h1, {31'h0, push_ready_o[i]});
        $display("test flush %0d done", i);
    endtask
    task automatic t_flush_all;
        en <= 1'b1;
        apb(1'b1, fifo_status_pkg::CONTROL_ADDR, 32'h2);
        repeat (2) @(posedge ref_clk_i);
        chk("sel other", 32'h0, {31'h0, push_ready_o[4]});
        chk("sel match", 32'h1, {31'h0, push_ready_o[6]});
        // Only the selected identity accepts bytes, so select each in turn
        for (int i = 4; i < 8; i++) begin
            apb(1'b1, fifo_status_pkg::CONTROL_ADDR, 32'(i - 4));
            push(i, 8'h3C);
        end
        repeat (2) @(posedge ref_clk_i);
        for (int i = 4; i < 8; i++) chk("id full", 32'h1, {31'h0, pop_o[i].valid});
        apb(1'b1, SA, 32'h400);
        apb(1'b0, SA, 32'h0);
        chk("all bit", 32'h1, {31'h0, rd[10]});
        for (int i = 4; i < 8; i++) chk("id empty", 32'h0, {31'h0, pop_o[i].valid});
        apb(1'b1, SA, 32'h0);
        en <= 1'b0;
        apb(1'b0, 12'h800, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test flush all done");
    endtask
    initial begin
        foreach (push_i[i]) push_i[i] = '{1'b0, 8'h00};
        foreach (pop_ready_i[i]) pop_ready_i[i] = 1'b0;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, SA, 32'h0);
        chk("reset", 32'h0, {16'h0, rd[15:0]});
        t_counts();
        t_flush(1, 9, 4);
        t_flush(3, 8, 0);
        t_flush_all();
        final_report();
    end
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20us;
        num_errors++;
        final_report();
    end
endmodule
